// ### core/dmc_pkg.sv
// Package for the module command-pin front end.
// Assumes one clock domain at 250 MHz with pins already sampled on that clock.
package dmc_pkg;
   localparam int ROW_W = 18;
   localparam int BG_W = 2;
   localparam int BA_W = 2;
   localparam int CID_W = 3;
   localparam int ROW_HI_POS = 14;
   localparam logic [1:0] STACK_NONE = 2'h0;
   localparam logic [1:0] STACK_2 = 2'h1;
   localparam logic [1:0] STACK_4 = 2'h2;
   localparam logic [1:0] STACK_8 = 2'h3;

   typedef struct packed {
      logic cs_n;
      logic act_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [CID_W-1:0] cid;
      logic [BG_W-1:0] bg;
      logic [BA_W-1:0] ba;
      logic [ROW_W-1:0] addr;
   } dmc_cmd_type;

   typedef enum logic [4:0] {
      CMD_DESEL = 5'h01,
      CMD_ACT = 5'h02,
      CMD_RDWR = 5'h04,
      CMD_OTHER = 5'h08,
      CMD_NOP = 5'h10
   } dmc_kind_type;

   typedef enum logic [3:0] {
      ST_ACTIVE = 4'h1,
      ST_PRE_PD = 4'h2,
      ST_ACT_PD = 4'h4,
      ST_SREF = 4'h8
   } dmc_pwr_type;

   typedef struct packed {
      logic clocks_on;
      logic cmd_buf_on;
      logic ctl_buf_on;
      logic drv_on;
   } dmc_gate_type;
endpackage : dmc_pkg

// ### core/dmc_decode.sv
// Combinational command decoder for one sampled command word.
// Assumes the caller registers its results.
`timescale 1ns/1ps
module dmc_decode
   import dmc_pkg::*;
(
   input wire dmc_cmd_type cmd,
   input wire logic [1:0] stack_mode,
   input wire logic [CID_W-1:0] my_slice,
   output dmc_kind_type kind,
   output logic [ROW_W-1:0] row,
   output logic hit
);
   function automatic logic [CID_W-1:0] cid_mask(input logic [1:0] mode);
      case (mode)
         STACK_2: cid_mask = 3'h1;
         STACK_4: cid_mask = 3'h3;
         STACK_8: cid_mask = 3'h7;
         default: cid_mask = 3'h0;
      endcase
   endfunction : cid_mask

   always_comb begin
      hit = !cmd.cs_n;
      if ((cmd.cid & cid_mask(stack_mode)) != (my_slice & cid_mask(stack_mode))) begin
         hit = 1'b0;
      end
      row = cmd.addr;
      kind = CMD_DESEL;
      if (hit) begin
         if (!cmd.act_n) begin
            kind = CMD_ACT;
            row[ROW_HI_POS+2] = cmd.ras_n;
            row[ROW_HI_POS+1] = cmd.cas_n;
            row[ROW_HI_POS] = cmd.we_n;
         end else if (cmd.ras_n && cmd.cas_n && cmd.we_n) begin
            kind = CMD_NOP;
         end else if (cmd.ras_n && !cmd.cas_n) begin
            kind = CMD_RDWR;
         end else begin
            kind = CMD_OTHER;
         end
      end
   end
endmodule : dmc_decode

// ### core/dmc_pins.sv
// Command-pin front end of a single-rank memory module: sampling, power states, termination.
// Assumes pins are synchronous to clk, sampled on the rising edge of the true clock.
//
// Behaviour
// - Capture all inputs on rising clock edge; sref_req, rtt_nom_en, stack_mode, my_slice, bank_open are used unregistered.
// - Clock enable gates clocks, buffers, drivers.
// - Low enable: idle gives precharge/self-refresh, else active.
// - Self-refresh exit recognised from sampled enable.
// - Power-down keeps only termination, enable buffers; clocks are gated.
// - Self-refresh keeps only enable buffer.
// - Chip select high masks the command.
// - Chip select is part of command code.
// - Chip identifier used only for stacked parts.
// - Chip identifier joins command code when used.
// - Termination pin high enables nominal termination.
// - Termination applies to data pins only.
// - Termination pin ignored when disabled in setup.
// - Activation pin with select marks activate.
// - Activate takes strobe pins as row bits 16..14.
// - Activation pin high decodes strobes as command.
`timescale 1ns/1ps
module dmc_pins
   import dmc_pkg::*;
#(
   parameter int NBANKS = 16
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire dmc_cmd_type cmd_pin,
   input wire logic cke,
   input wire logic odt,
   input wire logic sref_req,
   input wire logic rtt_nom_en,
   input wire logic [1:0] stack_mode,
   input wire logic [CID_W-1:0] my_slice,
   input wire logic [NBANKS-1:0] bank_open,
   output dmc_kind_type cmd_kind,
   output logic cmd_valid,
   output logic [ROW_W-1:0] cmd_row,
   output logic [BG_W-1:0] cmd_bg,
   output logic [BA_W-1:0] cmd_ba,
   output dmc_pwr_type pwr_state,
   output dmc_gate_type gates,
   output logic data_term_on,
   output logic sref_exit
);
   ////////////////////////////////////////////////////////////////////////////
   // Input sampling; command buffers are gated off in low-power states.
   dmc_cmd_type cap;
   dmc_cmd_type next_cap;
   logic cke_q;
   logic next_cke_q;
   logic odt_q;
   logic next_odt_q;
   dmc_kind_type dec_kind;
   logic [ROW_W-1:0] dec_row;
   logic dec_hit;

   // A gated buffer presents a deselect, so a sleeping part never sees a command.
   always_comb begin
      next_cap = cmd_pin;
      if (!gates.cmd_buf_on) begin
         next_cap = cap;
         next_cap.cs_n = 1'b1;
      end
      next_cke_q = cke;
      next_odt_q = 1'b0;
      if (gates.ctl_buf_on) begin
         next_odt_q = odt;
      end
   end

   // The sampled enable resets high, so leaving reset is never taken as a power-down.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cap <= '1;
         cke_q <= 1'b1;
         odt_q <= 1'b0;
      end else begin
         cap <= next_cap;
         cke_q <= next_cke_q;
         odt_q <= next_odt_q;
      end
   end

   dmc_decode u_dec (
      .cmd(cap),
      .stack_mode(stack_mode),
      .my_slice(my_slice),
      .kind(dec_kind),
      .row(dec_row),
      .hit(dec_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Power state machine driven by the sampled clock enable.
   dmc_pwr_type next_pwr;
   dmc_gate_type next_gates;
   logic next_exit;

   // One place decides which buffers and clocks a power state keeps alive.
   function automatic dmc_gate_type gates_for(input dmc_pwr_type s);
      dmc_gate_type g;
      g.clocks_on = (s == ST_ACTIVE);
      g.drv_on = (s == ST_ACTIVE);
      g.cmd_buf_on = (s == ST_ACTIVE);
      g.ctl_buf_on = (s != ST_SREF);
      return g;
   endfunction : gates_for

   always_comb begin
      next_pwr = pwr_state;
      next_exit = 1'b0;
      case (pwr_state)
         ST_ACTIVE: begin
            if (!cke_q) begin
               if (|bank_open) begin
                  next_pwr = ST_ACT_PD;
               end else if (sref_req) begin
                  next_pwr = ST_SREF;
               end else begin
                  next_pwr = ST_PRE_PD;
               end
            end
         end
         ST_PRE_PD, ST_ACT_PD: begin
            if (cke_q) begin
               next_pwr = ST_ACTIVE;
            end
         end
         ST_SREF: begin
            if (cke_q) begin
               next_pwr = ST_ACTIVE;
               next_exit = 1'b1;
            end
         end
         default: next_pwr = ST_ACTIVE;
      endcase
      next_gates = gates_for(next_pwr);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pwr_state <= ST_ACTIVE;
         gates <= 4'hF;
         sref_exit <= 1'b0;
      end else begin
         pwr_state <= next_pwr;
         gates <= next_gates;
         sref_exit <= next_exit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered command outputs and data-pin termination.
   // Termination drives only the data-side enable; command pins have none.
   // Outputs cost one cycle of latency so that each of them leaves a flip-flop.
   dmc_kind_type next_cmd_kind;
   logic next_cmd_valid;
   logic [ROW_W-1:0] next_cmd_row;
   logic [BG_W-1:0] next_cmd_bg;
   logic [BA_W-1:0] next_cmd_ba;
   logic next_data_term_on;

   always_comb begin
      next_cmd_kind = dec_kind;
      next_cmd_valid = dec_hit && gates.clocks_on;
      next_cmd_row = dec_row;
      next_cmd_bg = cap.bg;
      next_cmd_ba = cap.ba;
      next_data_term_on = odt_q && rtt_nom_en;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmd_kind <= CMD_DESEL;
         cmd_valid <= 1'b0;
         cmd_row <= '0;
         cmd_bg <= '0;
         cmd_ba <= '0;
         data_term_on <= 1'b0;
      end else begin
         cmd_kind <= next_cmd_kind;
         cmd_valid <= next_cmd_valid;
         cmd_row <= next_cmd_row;
         cmd_bg <= next_cmd_bg;
         cmd_ba <= next_cmd_ba;
         data_term_on <= next_data_term_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   chk_cs_masks: assert property (@(posedge clk) disable iff (!rstn)
      cap.cs_n |=> !cmd_valid && cmd_kind == CMD_DESEL)
      else $error("Command with select high not masked.");
   chk_act_row: assert property (@(posedge clk) disable iff (!rstn)
      (dec_hit && !cap.act_n) |=> cmd_kind == CMD_ACT
         && cmd_row[ROW_HI_POS+2:ROW_HI_POS] == $past({cap.ras_n, cap.cas_n, cap.we_n}))
      else $error("Activate row bits wrong.");
   chk_rdwr_decode: assert property (@(posedge clk) disable iff (!rstn)
      (dec_hit && cap.act_n && cap.ras_n && !cap.cas_n) |=> cmd_kind == CMD_RDWR)
      else $error("Read or write not decoded.");
   chk_term_gate: assert property (@(posedge clk) disable iff (!rstn)
      !rtt_nom_en |=> !data_term_on)
      else $error("Termination on while disabled.");
   chk_term_on: assert property (@(posedge clk) disable iff (!rstn)
      (odt && gates.ctl_buf_on && rtt_nom_en) ##1 rtt_nom_en |=> data_term_on)
      else $error("Termination not applied.");
   chk_pd_entry: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_state == ST_ACTIVE && !cke_q && |bank_open) |=> pwr_state == ST_ACT_PD)
      else $error("Active power-down not entered.");
   chk_sref_exit: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_state == ST_SREF && cke_q) |=> sref_exit && pwr_state == ST_ACTIVE)
      else $error("Self-refresh exit missed.");
   chk_sref_bufs: assert property (@(posedge clk) disable iff (!rstn)
      pwr_state == ST_SREF |-> !gates.ctl_buf_on && !gates.cmd_buf_on && !gates.drv_on)
      else $error("Buffers on in self-refresh.");
   chk_pd_bufs: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_state == ST_PRE_PD || pwr_state == ST_ACT_PD)
         |-> gates.ctl_buf_on && !gates.cmd_buf_on)
      else $error("Power-down buffer gating wrong.");
   chk_clk_gate: assert property (@(posedge clk) disable iff (!rstn)
      gates.clocks_on == (pwr_state == ST_ACTIVE))
      else $error("Clock gating out of step.");

   ////////////////////////////////////////////////////////////////////////////
   // Checks on capture and decode; apart from the enable-sampling check, they watch the captured word, not the pins.
   chk_valid_kind: assert property (@(posedge clk) disable iff (!rstn)
      cmd_valid |-> cmd_kind != CMD_DESEL)
      else $error("Valid command reported as deselect.");
   chk_nop_decode: assert property (@(posedge clk) disable iff (!rstn)
      (dec_hit && cap.act_n && cap.ras_n && cap.cas_n && cap.we_n)
         |=> cmd_kind == CMD_NOP)
      else $error("No-operation not decoded.");
   chk_other_decode: assert property (@(posedge clk) disable iff (!rstn)
      (dec_hit && cap.act_n && !(cap.ras_n && cap.cas_n && cap.we_n)
         && !(cap.ras_n && !cap.cas_n)) |=> cmd_kind == CMD_OTHER)
      else $error("Other command not decoded.");
   chk_row_pass: assert property (@(posedge clk) disable iff (!rstn)
      (dec_hit && cap.act_n) |=> cmd_row == $past(cap.addr))
      else $error("Address altered outside activate.");
   chk_cmd_bank: assert property (@(posedge clk) disable iff (!rstn)
      dec_hit |=> cmd_bg == $past(cap.bg) && cmd_ba == $past(cap.ba))
      else $error("Bank address not carried.");
   chk_stack_none: assert property (@(posedge clk) disable iff (!rstn)
      (stack_mode == STACK_NONE && !cap.cs_n) |-> dec_hit)
      else $error("Unstacked part ignored a selected command.");
   chk_slice_miss: assert property (@(posedge clk) disable iff (!rstn)
      (!cap.cs_n && stack_mode == STACK_8 && cap.cid != my_slice) |-> !dec_hit)
      else $error("Command for another slice accepted.");
   chk_valid_awake: assert property (@(posedge clk) disable iff (!rstn)
      cmd_valid |-> $past(gates.clocks_on))
      else $error("Command reported with clocks off.");
   chk_sleep_desel: assert property (@(posedge clk) disable iff (!rstn)
      !gates.cmd_buf_on |=> cap.cs_n)
      else $error("Command captured through a gated buffer.");
   chk_cke_sample: assert property (@(posedge clk) disable iff (!rstn)
      rstn |=> cke_q == $past(cke))
      else $error("Clock enable not sampled.");

   ////////////////////////////////////////////////////////////////////////////
   // Checks on power states, gating and termination.
   chk_ppd_entry: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_state == ST_ACTIVE && !cke_q && !(|bank_open) && !sref_req)
         |=> pwr_state == ST_PRE_PD)
      else $error("Precharge power-down not entered.");
   chk_sref_entry: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_state == ST_ACTIVE && !cke_q && !(|bank_open) && sref_req)
         |=> pwr_state == ST_SREF)
      else $error("Self-refresh not entered.");
   chk_pd_hold: assert property (@(posedge clk) disable iff (!rstn)
      ((pwr_state == ST_PRE_PD || pwr_state == ST_ACT_PD) && !cke_q)
         |=> $stable(pwr_state))
      else $error("Power-down left with enable low.");
   chk_pd_wake: assert property (@(posedge clk) disable iff (!rstn)
      ((pwr_state == ST_PRE_PD || pwr_state == ST_ACT_PD) && cke_q)
         |=> pwr_state == ST_ACTIVE && !sref_exit)
      else $error("Power-down exit wrong.");
   chk_sref_hold: assert property (@(posedge clk) disable iff (!rstn)
      (pwr_state == ST_SREF && !cke_q) |=> pwr_state == ST_SREF && !sref_exit)
      else $error("Self-refresh left with enable low.");
   chk_exit_pulse: assert property (@(posedge clk) disable iff (!rstn)
      sref_exit |=> !sref_exit)
      else $error("Self-refresh exit pulse too long.");
   chk_awake_gates: assert property (@(posedge clk) disable iff (!rstn)
      pwr_state == ST_ACTIVE |-> gates.clocks_on && gates.cmd_buf_on
         && gates.ctl_buf_on && gates.drv_on)
      else $error("Gate off while active.");
   chk_pd_drivers: assert property (@(posedge clk) disable iff (!rstn)
      pwr_state != ST_ACTIVE |-> !gates.clocks_on && !gates.drv_on)
      else $error("Clocks or drivers on while asleep.");
   chk_odt_gate: assert property (@(posedge clk) disable iff (!rstn)
      !gates.ctl_buf_on |=> !odt_q)
      else $error("Termination pin taken through a gated buffer.");
   chk_odt_sample: assert property (@(posedge clk) disable iff (!rstn)
      gates.ctl_buf_on |=> odt_q == $past(odt))
      else $error("Termination pin not sampled.");

   cov_act: cover property (@(posedge clk) disable iff (!rstn) cmd_kind == CMD_ACT);
   cov_sref: cover property (@(posedge clk) disable iff (!rstn) sref_exit);
   cov_apd: cover property (@(posedge clk) disable iff (!rstn) pwr_state == ST_ACT_PD);
   cov_term: cover property (@(posedge clk) disable iff (!rstn) data_term_on);
   cov_ppd: cover property (@(posedge clk) disable iff (!rstn) pwr_state == ST_PRE_PD);
endmodule : dmc_pins

// ### test/dmc_ctl_model.sv
// Controller-side model that drives the command, clock enable and termination pins.
// Assumes the bench calls its tasks from a process clocked by clk.
`timescale 1ns/1ps
module dmc_ctl_model
   import dmc_pkg::*;
(
   input wire logic clk,
   output dmc_cmd_type cmd_pin,
   output logic cke,
   output logic odt
);
   initial begin
      cmd_pin = '1;
      cke = 1'h1;
      odt = 1'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // A command stands for one cycle, then the select is raised again.
   // The other lines take the inverse of their last value, because a real bus holds nothing.
   task automatic send(input dmc_cmd_type c);
      dmc_cmd_type n;
      @(posedge clk);
      cmd_pin <= c;
      n = ~c;
      n.cs_n = 1'h1;
      @(posedge clk);
      cmd_pin <= n;
   endtask : send
   // Clock enable only moves between single-cycle commands, never inside an access.
   task automatic pins(input logic k, input logic o);
      @(posedge clk);
      cke <= k;
      odt <= o;
   endtask : pins
endmodule : dmc_ctl_model

// ### test/dmc_pins_bench.sv
// Self-checking bench for the command-pin front end.
// Assumes the controller model drives the pins and the bench drives the settings.
`timescale 1ns/1ps
module dmc_pins_bench;
   import dmc_pkg::*;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic sref_req = 1'h0;
   logic rtt_nom_en = 1'h1;
   logic [1:0] stack_mode = STACK_NONE;
   logic [CID_W-1:0] my_slice = 3'h0;
   logic [15:0] bank_open = 16'h0000;
   dmc_cmd_type cmd_pin;
   logic cke, odt, cmd_valid, data_term_on, sref_exit, seen;
   dmc_kind_type cmd_kind;
   logic [ROW_W-1:0] cmd_row;
   logic [BG_W-1:0] cmd_bg;
   logic [BA_W-1:0] cmd_ba;
   dmc_pwr_type pwr_state;
   dmc_gate_type gates;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   always #2 clk = ~clk;
   dmc_ctl_model m (.clk(clk), .cmd_pin(cmd_pin), .cke(cke), .odt(odt));
   dmc_pins dut (.clk(clk), .rstn(rstn), .cmd_pin(cmd_pin), .cke(cke), .odt(odt),
      .sref_req(sref_req), .rtt_nom_en(rtt_nom_en), .stack_mode(stack_mode),
      .my_slice(my_slice), .bank_open(bank_open), .cmd_kind(cmd_kind), .cmd_valid(cmd_valid),
      .cmd_row(cmd_row), .cmd_bg(cmd_bg), .cmd_ba(cmd_ba), .pwr_state(pwr_state),
      .gates(gates), .data_term_on(data_term_on), .sref_exit(sref_exit));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   function automatic dmc_cmd_type mk(input logic cs, input logic [3:0] c, input logic [2:0] id);
      mk = {cs, c, id, 4'h6, 18'h0A5C3};
   endfunction : mk
   // Results land two edges after the pins, so both waits end one step past that edge.
   task automatic wait2();
      repeat (2) @(posedge clk);
      #1;
   endtask : wait2
   task automatic issue(input dmc_cmd_type c);
      m.send(c);
      @(posedge clk);
      #1;
   endtask : issue
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_decode();
      logic [2:0] p;
      for (int i = 0; i < 2; i++) begin
         p = i ? 3'h2 : 3'h5;
         issue(mk(1'h0, {1'h0, p}, 3'h0));
         chk("act_kind", CMD_ACT, cmd_kind);
         chk("act_valid", 1'h1, cmd_valid);
         chk("act_row", {p, 14'h25C3}, cmd_row[16:0]);
         chk("act_bank", 4'h6, {cmd_bg, cmd_ba});
      end
      issue(mk(1'h0, 4'hD, 3'h0));
      chk("rdwr_kind", CMD_RDWR, cmd_kind);
      issue(mk(1'h0, 4'hB, 3'h0));
      chk("other_kind", CMD_OTHER, cmd_kind);
      issue(mk(1'h0, 4'hF, 3'h0));
      chk("nop_kind", CMD_NOP, cmd_kind);
      issue(mk(1'h1, 4'h0, 3'h0));
      chk("desel_kind", CMD_DESEL, cmd_kind);
      chk("desel_valid", 1'h0, cmd_valid);
   endtask : t_decode
   task automatic t_slice();
      for (int i = 1; i < 4; i++) begin
         @(posedge clk) stack_mode <= 2'(i);
         issue(mk(1'h0, 4'h5, 3'(1 << (i - 1))));
         chk("slice_miss", CMD_DESEL, cmd_kind);
         issue(mk(1'h0, 4'h5, 3'(1 << i)));
         chk("slice_hit", CMD_ACT, cmd_kind);
      end
      @(posedge clk) my_slice <= 3'h5;
      stack_mode <= STACK_8;
      issue(mk(1'h0, 4'h5, 3'h4));
      chk("slice5_miss", CMD_DESEL, cmd_kind);
      issue(mk(1'h0, 4'h5, 3'h5));
      chk("slice5_hit", CMD_ACT, cmd_kind);
      @(posedge clk) stack_mode <= STACK_NONE;
      issue(mk(1'h0, 4'h5, 3'h3));
      chk("no_stack", CMD_ACT, cmd_kind);
   endtask : t_slice
   task automatic t_power();
      m.pins(1'h0, 1'h0);
      wait2();
      chk("pre_pd", ST_PRE_PD, pwr_state);
      chk("pd_gates", 4'h2, gates);
      m.pins(1'h1, 1'h0);
      wait2();
      chk("wake", ST_ACTIVE, pwr_state);
      chk("wake_gates", 4'hF, gates);
      @(posedge clk) bank_open <= 16'h0100;
      m.pins(1'h0, 1'h0);
      wait2();
      chk("act_pd", ST_ACT_PD, pwr_state);
      m.pins(1'h1, 1'h0);
      @(posedge clk) bank_open <= 16'h0000;
      sref_req <= 1'h1;
      m.pins(1'h0, 1'h0);
      wait2();
      chk("sref", ST_SREF, pwr_state);
      chk("sr_gates", 4'h0, gates);
      m.pins(1'h1, 1'h0);
      seen = 1'h0;
      repeat (4) @(posedge clk) begin
         #1 seen |= sref_exit;
      end
      chk("sr_exit", 1'h1, seen);
      chk("sr_back", ST_ACTIVE, pwr_state);
   endtask : t_power
   task automatic t_term();
      m.pins(1'h1, 1'h1);
      wait2();
      chk("term_on", 1'h1, data_term_on);
      m.pins(1'h1, 1'h0);
      wait2();
      chk("term_off", 1'h0, data_term_on);
      @(posedge clk) rtt_nom_en <= 1'h0;
      m.pins(1'h1, 1'h1);
      wait2();
      chk("term_masked", 1'h0, data_term_on);
   endtask : t_term
   ////////////////////////////////////////////////////////////////////////////////
   // The whole run needs some 85 cycles, so 3000 leaves ample margin.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      t_decode();
      t_slice();
      t_power();
      t_term();
      wrap_up();
   end
endmodule : dmc_pins_bench
